/* File: rtl/dioa_pkg.sv */
/*
 * shared constants and carriers of the digital i/o and channel a block.
 * assumes a byte-offset i/o bus and a 50 MHz board clock.
 */
package dioa_pkg;

    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [3:0] OFF_DIO = 4'h3;
    localparam logic [3:0] OFF_CHA_LOW = 4'h4;
    localparam logic [3:0] OFF_CHA_HIGH = 4'h5;

    // --------------------------------------------------------------
    // field layout and reset values
    // --------------------------------------------------------------
    localparam int DIO_W = 4;
    localparam int CODE_W = 16;
    localparam int BYTE_W = 8;
    localparam int ALIGN_PAD_W = 4;
    localparam int LEGACY_W = 12;
    localparam int GATE_BIT = 2;
    localparam logic [3:0] DOUT_RESET = 4'h0;
    localparam logic [15:0] CODE_ZERO_UNI = 16'h0000;
    localparam logic [15:0] CODE_ZERO_BI = 16'h8000;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int DEGLITCH_NS = 200;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DGL_CNT_W = 4;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic word16;
        logic [3:0] offset;
        logic [15:0] wdata;
    } dioa_bus_req_s;

    typedef struct packed {
        logic polarity;
        logic span;
    } dioa_range_s;

endpackage

/* File: rtl/dioa_deglitch.sv */
/*
 * match filter: output follows the input once it has held a new level
 * for the full deglitch time.
 * assumes the input is already synchronous to ref_clk.
 */
`timescale 1ns/1ps
module dioa_deglitch (
    input wire logic ref_clk, // board clock
    input wire logic rst, // async reset
    input wire logic raw_in, // sampled input
    output logic clean_q // filtered level
);
    localparam logic [3:0] LAST =
        4'(dioa_pkg::DEGLITCH_CYC - 1);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic differ;
    logic accept;

    assign differ = raw_in != clean_q;
    assign accept = differ && (cnt_q == LAST);
    assign cnt_d = (differ && !accept) ? cnt_q + 4'h1 : 4'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            clean_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            if (accept) begin
                clean_q <= raw_in;
            end
        end
    end
endmodule

/* File: rtl/dioa_chan_a.sv */
/*
 * channel a code staging and commit.
 * assumes one-cycle write strobes and static range straps.
 */
`timescale 1ns/1ps
module dioa_chan_a (
    input wire logic ref_clk, // board clock
    input wire logic rst, // async reset
    input wire logic ld_low, // low byte write
    input wire logic ld_high, // high byte write
    input wire logic ld_word, // word write
    input wire logic [15:0] wdata, // write data
    input wire logic align16, // 1: full 16-bit placement
    input wire dioa_pkg::dioa_range_s straps, // range straps
    output logic [15:0] code_q, // converter code
    output logic update_q, // converter load pulse
    output dioa_pkg::dioa_range_s range_q // applied range
);
    logic [7:0] low_q;
    logic init_q;
    logic commit;
    logic [15:0] word;
    logic [15:0] placed;
    logic [15:0] zero_code;

    // staged low byte joins the new high byte unless a word arrives
    assign commit = ld_high || ld_word;
    assign word = ld_word ? wdata : {wdata[7:0], low_q};
    assign placed = align16 ? word
        : {word[dioa_pkg::LEGACY_W-1:0], {dioa_pkg::ALIGN_PAD_W{1'b0}}};
    assign zero_code = straps.polarity ? dioa_pkg::CODE_ZERO_BI
        : dioa_pkg::CODE_ZERO_UNI;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_q <= 8'h00;
            init_q <= 1'b1;
            code_q <= dioa_pkg::CODE_ZERO_UNI;
            update_q <= 1'b0;
            range_q <= '0;
        end else begin
            init_q <= 1'b0;
            update_q <= commit || init_q;
            if (ld_low) begin
                low_q <= wdata[7:0];
            end
            if (ld_word) begin
                low_q <= wdata[7:0];
            end
            if (init_q) begin
                code_q <= zero_code;
                range_q <= straps;
            end else if (commit) begin
                code_q <= placed;
                range_q <= straps;
            end
        end
    end
endmodule

/* File: rtl/dioa_top.sv */
/*
 * digital outputs, digital inputs with mode bits, and channel a code
 * register behind a byte-offset i/o port.
 * assumes bus strobes are one-cycle pulses synchronous to ref_clk,
 * that the board straps are static, and that pin inputs are
 * synchronous to ref_clk.
 */
// Functional notes
// - a write at offset 3 latches data bits 3..0 onto the four outputs, which reset to zero.
// - a read at offset 3 returns the input levels on bits 3..0 and the mode on bits 7..6.
// - both mode bits read zero in the first legacy mode and one in the second.
// - input zero is also the converter trigger, passed only after a 200 ns stable pulse.
// - input two also drives the counter-zero gate and stays readable.
// - the channel a code is 16 bits, low byte at offset 4, high byte at offset 5.
// - the channel a output updates only on a high byte write, a word write at offset 4, or the first cycle after reset.
// - a high byte write alone updates with the low byte currently held.
// - a word write at offset 4 loads both bytes and updates the output.
// - a new range setting takes effect only on the next high byte write or word write, or in the first cycle after reset.
// - after reset the output code stands for zero volts.
// - two range straps pick polarity and span; with bipolar polarity 0x0000 is negative and 0xFFFF positive full scale.
// - the analog output is held disabled during reset and enabled from the first clock after it, with no enable control.
// - code placement is selectable between 12-bit legacy and full 16-bit.
`timescale 1ns/1ps
module dioa_top (
    input wire logic ref_clk, // board clock, 50 MHz
    input wire logic rst, // async reset, active high
    input wire dioa_pkg::dioa_bus_req_s bus_req, // i/o bus request
    input wire logic [3:0] din, // digital input pins
    input wire logic compat_select_bits, // 1: second legacy mode
    input wire logic align_16bit, // 1: full 16-bit code placement
    input wire dioa_pkg::dioa_range_s output_range_straps, // range straps
    output logic [15:0] rdata_q, // read data
    output logic rd_valid_q, // read data valid pulse
    output logic [3:0] dout_q, // digital output pins
    output logic input_zero_trigger_q, // filtered trigger
    output logic input_two_counter_gate_q, // counter zero gate
    output logic [15:0] chan_a_code_q, // converter code
    output logic chan_a_update_q, // converter load pulse
    output logic chan_a_polarity_select_q, // applied polarity
    output logic chan_a_span_select_q, // applied span
    output logic chan_a_enable_q // converter output enable
);

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------
    logic hit_dio;
    logic hit_low;
    logic hit_high;
    logic wr_dout;
    logic rd_din;
    logic ld_low;
    logic ld_high;
    logic ld_word;

    // one offset compare, shared by every register select
    function automatic logic at_offset(input logic [3:0] off, input logic [3:0] want);
        return off == want;
    endfunction

    assign hit_dio = at_offset(bus_req.offset, dioa_pkg::OFF_DIO);
    assign hit_low = at_offset(bus_req.offset, dioa_pkg::OFF_CHA_LOW);
    assign hit_high = at_offset(bus_req.offset, dioa_pkg::OFF_CHA_HIGH);
    assign wr_dout = bus_req.wr && hit_dio;
    assign rd_din = bus_req.rd && hit_dio;
    assign ld_low = bus_req.wr && hit_low && !bus_req.word16;
    assign ld_word = bus_req.wr && hit_low && bus_req.word16;
    assign ld_high = bus_req.wr && hit_high;

    // --------------------------------------------------------------
    // input sampling
    // --------------------------------------------------------------
    logic [3:0] din_q;
    logic compat_q;
    logic [7:0] in_byte;

    // mode bits sit in bits 7 and 6, bits 5 and 4 read zero
    assign in_byte = {compat_q, compat_q, 2'b00, din_q};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            din_q <= 4'h0;
        end else begin
            din_q <= din;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            compat_q <= 1'b0;
        end else begin
            compat_q <= compat_select_bits;
        end
    end

    // --------------------------------------------------------------
    // digital outputs and read port
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dout_q <= dioa_pkg::DOUT_RESET;
        end else if (wr_dout) begin
            dout_q <= bus_req.wdata[dioa_pkg::DIO_W-1:0];
        end
    end

    // outputs are write only; other offsets read as zero
    logic [7:0] rd_byte;
    logic [15:0] rd_word;

    assign rd_byte = rd_din ? in_byte : dioa_pkg::RD_IDLE;
    assign rd_word = {dioa_pkg::RD_IDLE, rd_byte};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= bus_req.rd;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= {2{dioa_pkg::RD_IDLE}};
        end else if (bus_req.rd) begin
            rdata_q <= rd_word;
        end
    end

    // --------------------------------------------------------------
    // trigger filter and counter gate
    // --------------------------------------------------------------
    dioa_deglitch u_trig (
        .ref_clk(ref_clk),
        .rst(rst),
        .raw_in(din_q[0]),
        .clean_q(input_zero_trigger_q)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            input_two_counter_gate_q <= 1'b0;
        end else begin
            input_two_counter_gate_q <= din_q[dioa_pkg::GATE_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan_a_enable_q <= 1'b0;
        end else begin
            chan_a_enable_q <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // channel a
    // --------------------------------------------------------------
    dioa_pkg::dioa_range_s range_q;

    dioa_chan_a u_cha (
        .ref_clk(ref_clk),
        .rst(rst),
        .ld_low(ld_low),
        .ld_high(ld_high),
        .ld_word(ld_word),
        .wdata(bus_req.wdata),
        .align16(align_16bit),
        .straps(output_range_straps),
        .code_q(chan_a_code_q),
        .update_q(chan_a_update_q),
        .range_q(range_q)
    );

    // applied polarity and span bits go straight to the converter range pins
    assign chan_a_polarity_select_q = range_q.polarity;
    assign chan_a_span_select_q = range_q.span;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic commit_w;
    logic past_rst_q;
    assign commit_w = ld_high || ld_word;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            past_rst_q <= 1'b1;
        end else begin
            past_rst_q <= 1'b0;
        end
    end

    a_dout_latch: assert property (
        wr_dout |=> dout_q == $past(bus_req.wdata[3:0]))
        else $error("output latch missed a write");

    a_dout_steady: assert property (
        !wr_dout |=> $stable(dout_q))
        else $error("outputs changed without a write");

    a_din_read: assert property (
        rd_din |=> rd_valid_q && rdata_q[3:0] == $past(din_q)
            && rdata_q[5:4] == 2'b00)
        else $error("input byte read wrong");

    a_mode_bits: assert property (
        rd_din |=> rdata_q[7:6] == {2{$past(compat_q)}})
        else $error("mode bits read wrong");

    a_trig_width: assert property (
        $changed(input_zero_trigger_q) |->
            $past(din_q[0], dioa_pkg::DEGLITCH_CYC) == input_zero_trigger_q
            && $past(din_q[0], 1) == input_zero_trigger_q)
        else $error("trigger passed a short pulse");

    a_trig_short: assert property (
        (din_q[0] != input_zero_trigger_q) ##1
            (din_q[0] == input_zero_trigger_q) |=>
            $stable(input_zero_trigger_q))
        else $error("trigger followed a glitch");

    a_gate_follow: assert property (
        ##1 input_two_counter_gate_q == $past(din_q[2]))
        else $error("counter gate not following input two");

    a_low_staged: assert property (
        (ld_low && !past_rst_q) |=> !chan_a_update_q && $stable(chan_a_code_q))
        else $error("low byte write moved the output");

    a_update_cause: assert property (
        (chan_a_update_q && !$past(past_rst_q)) |-> $past(commit_w))
        else $error("update without a high byte write");

    a_high_commit: assert property (
        (ld_low && align_16bit) ##1 (ld_high && align_16bit) |=>
            chan_a_update_q
            && chan_a_code_q == {$past(bus_req.wdata[7:0]),
                $past(bus_req.wdata[7:0], 2)})
        else $error("high byte commit lost the staged low byte");

    a_word_commit: assert property (
        (ld_word && align_16bit) |=> chan_a_update_q
            && chan_a_code_q == $past(bus_req.wdata))
        else $error("word write not committed");

    a_range_hold: assert property (
        (!commit_w && !past_rst_q) |=> $stable(chan_a_polarity_select_q)
            && $stable(chan_a_span_select_q))
        else $error("range changed without a commit");

    a_range_take: assert property (
        commit_w |=> {chan_a_polarity_select_q, chan_a_span_select_q}
            == $past(output_range_straps))
        else $error("range not taken on commit");

    a_reset_zero: assert property (
        past_rst_q ##1 !past_rst_q |-> chan_a_code_q ==
            (output_range_straps.polarity ? dioa_pkg::CODE_ZERO_BI : dioa_pkg::CODE_ZERO_UNI))
        else $error("reset code is not zero volts");

    a_always_on: assert property (
        !past_rst_q |-> chan_a_enable_q)
        else $error("converter output disabled");

    a_legacy_place: assert property (
        (ld_word && !align_16bit) |=>
            chan_a_code_q == {$past(bus_req.wdata[11:0]), 4'h0})
        else $error("legacy placement wrong");

    a_rd_pulse: assert property (
        bus_req.rd |=> rd_valid_q)
        else $error("read answer missing");

    a_rd_quiet: assert property (
        !bus_req.rd |=> !rd_valid_q && $stable(rdata_q))
        else $error("read port moved without a read");

    a_rd_unmapped: assert property (
        (bus_req.rd && !hit_dio) |=> rdata_q == {2{dioa_pkg::RD_IDLE}})
        else $error("unmapped read not zero");

    a_rd_upper: assert property (
        rd_din |=> rdata_q[15:8] == dioa_pkg::RD_IDLE)
        else $error("upper read byte not zero");

    a_gate_read: assert property (
        rd_din |=> rdata_q[dioa_pkg::GATE_BIT] == input_two_counter_gate_q)
        else $error("gate level not readable");

    a_trig_hold: assert property (
        (din_q[0] == input_zero_trigger_q) |=> $stable(input_zero_trigger_q))
        else $error("trigger moved with a steady input");

    a_update_pulse: assert property (
        commit_w |=> chan_a_update_q)
        else $error("commit without update pulse");

    a_update_single: assert property (
        (chan_a_update_q && !commit_w) |=> !chan_a_update_q)
        else $error("update pulse longer than one cycle");

    a_code_hold: assert property (
        (!commit_w && !past_rst_q) |=> $stable(chan_a_code_q))
        else $error("code moved without a commit");

    a_high_byte: assert property (
        (ld_high && align_16bit && !past_rst_q) |=>
            chan_a_code_q[15:8] == $past(bus_req.wdata[7:0]))
        else $error("high byte not placed");

    a_pad_zero: assert property (
        (commit_w && !align_16bit) |=> chan_a_code_q[dioa_pkg::ALIGN_PAD_W-1:0] == '0)
        else $error("legacy pad bits not zero");

    a_legacy_high: assert property (
        (ld_high && !align_16bit && !past_rst_q) |=>
            chan_a_code_q[15:12] == $past(bus_req.wdata[3:0]))
        else $error("legacy high byte misplaced");

    a_init_update: assert property (
        past_rst_q |=> chan_a_update_q)
        else $error("no update after reset");

    // --------------------------------------------------------------
    // cover points
    // --------------------------------------------------------------
    c_legacy_high: cover property (ld_high && !align_16bit);
    c_byte_pair: cover property (ld_low ##[1:4] ld_high);
    c_word_write: cover property (ld_word ##1 chan_a_update_q);
    c_trig_rise: cover property ($rose(input_zero_trigger_q));
    c_din_read: cover property (rd_din ##1 rd_valid_q);

endmodule

/* File: dv/dioa_host.sv */
/*
 * host model: issues byte and word cycles on the block's i/o port.
 * assumes one-cycle strobes and a read answer one cycle after rd.
 */
`timescale 1ns/1ps
module dioa_host (
    input wire logic ref_clk, // board clock
    input wire logic [15:0] rdata_q, // read data from block
    input wire logic rd_valid_q, // read valid pulse
    output dioa_pkg::dioa_bus_req_s bus_req, // request to block
    output logic [3:0] dout_shadow // software copy of outputs
);
    initial begin
        bus_req = '0;
        dout_shadow = 4'h0;
    end

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic write(input logic [3:0] off, input logic [15:0] data, input logic w16);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, word16: w16, offset: off, wdata: data};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask

    task automatic read(input logic [3:0] off, output logic [15:0] data, output logic ok);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, word16: 1'b0, offset: off, wdata: 16'h0000};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        ok = rd_valid_q;
        data = rdata_q;
    endtask

    // low then high byte on consecutive edges
    task automatic write_pair(input logic [15:0] low, input logic [15:0] high);
        @(posedge ref_clk);
        bus_req <= '{1'b1, 1'b0, 1'b0, dioa_pkg::OFF_CHA_LOW, low};
        @(posedge ref_clk);
        bus_req <= '{1'b1, 1'b0, 1'b0, dioa_pkg::OFF_CHA_HIGH, high};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask

    // outputs cannot be read back: change one bit in the copy
    task automatic set_bit(input int idx, input logic val);
        dout_shadow[idx] = val;
        write(dioa_pkg::OFF_DIO, {12'h000, dout_shadow}, 1'b0);
    endtask
endmodule

/* File: dv/tb.sv */
/*
 * self-checking bench of the digital i/o and channel a block.
 * assumes the host model drives the i/o port.
 */
`timescale 1ns/1ps
module tb;
    logic ref_clk, rst, compat, align, ok, trig, gate, en, upd, pol, spn;
    logic [3:0] din, dout, shadow;
    logic [15:0] rdata, code, rd;
    logic rd_valid;
    dioa_pkg::dioa_bus_req_s bus_req;
    dioa_pkg::dioa_range_s straps;
    int errors, total_checks, upd_cnt, trig_cnt, u0, t0;

    dioa_host host_u (.ref_clk(ref_clk), .rdata_q(rdata), .rd_valid_q(rd_valid),
        .bus_req(bus_req), .dout_shadow(shadow));

    dioa_top dut_u (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .din(din),
        .compat_select_bits(compat), .align_16bit(align), .output_range_straps(straps),
        .rdata_q(rdata), .rd_valid_q(rd_valid), .dout_q(dout),
        .input_zero_trigger_q(trig), .input_two_counter_gate_q(gate),
        .chan_a_code_q(code), .chan_a_update_q(upd), .chan_a_polarity_select_q(pol),
        .chan_a_span_select_q(spn), .chan_a_enable_q(en));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (upd === 1'b1) upd_cnt++;
        if (trig === 1'b1) trig_cnt++;
    end

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            errors++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic do_reset(input logic p);
        @(posedge ref_clk);
        rst <= 1'b1;
        straps <= '{polarity: p, span: 1'b0};
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        chk_val("code", p ? 16'h8000 : 16'h0000, code);
        chk_val("dout", 16'h0000, {12'h000, dout});
        chk_val("enable", 16'h0001, {15'h0000, en});
        $display("test reset done");
    endtask

    task automatic commit(input logic [3:0] off, input logic [15:0] d, input logic w16,
                          input int n, input logic [15:0] exp);
        u0 = upd_cnt;
        host_u.write(off, d, w16);
        settle();
        chk_cnt("update count", u0 + n, upd_cnt);
        chk_val("chan a code", exp, code);
    endtask

    task automatic pulse0(input int n, input int exp);
        t0 = trig_cnt;
        @(posedge ref_clk);
        din[0] <= 1'b1;
        repeat (n) @(posedge ref_clk);
        din[0] <= 1'b0;
        repeat (24) @(posedge ref_clk);
        chk_cnt("trigger width", exp, trig_cnt - t0);
    endtask

    initial begin
        #400000;
        errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        upd_cnt = 0;
        trig_cnt = 0;
        rst = 1'b1;
        din = 4'h0;
        compat = 1'b0;
        align = 1'b1;
        straps = '{polarity: 1'b1, span: 1'b0};
        do_reset(1'b1);
        chk_cnt("init update", 1, upd_cnt);

        host_u.write(dioa_pkg::OFF_DIO, 16'h00F5, 1'b0);
        settle();
        chk_val("dout", 16'h0005, {12'h000, dout});
        host_u.set_bit(1, 1'b1);
        host_u.set_bit(0, 1'b0);
        settle();
        chk_val("dout rmw", 16'h0002, {12'h000, dout});
        chk_val("dout shadow", {12'h000, shadow}, {12'h000, dout});
        $display("test outputs done");

        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            compat <= i[0];
            din <= i[1] ? 4'hA : 4'h5;
            settle();
            host_u.read(dioa_pkg::OFF_DIO, rd, ok);
            chk_val("read valid", 16'h0001, {15'h0000, ok});
            chk_val("din byte", {8'h00, {2{i[0]}}, 2'b00, (i[1] ? 4'hA : 4'h5)}, rd);
            chk_val("gate", {15'h0000, din[2]}, {15'h0000, gate});
        end
        host_u.read(4'h9, rd, ok);
        chk_val("unmapped read", 16'h0000, rd);
        @(posedge ref_clk);
        din <= 4'h0;
        $display("test inputs done");

        commit(dioa_pkg::OFF_CHA_LOW, 16'h0034, 1'b0, 0, 16'h8000);
        commit(dioa_pkg::OFF_CHA_HIGH, 16'h0012, 1'b0, 1, 16'h1234);
        commit(dioa_pkg::OFF_CHA_HIGH, 16'h0056, 1'b0, 1, 16'h5634);
        commit(dioa_pkg::OFF_CHA_LOW, 16'hBEEF, 1'b1, 1, 16'hBEEF);
        commit(dioa_pkg::OFF_CHA_HIGH, 16'h0001, 1'b0, 1, 16'h01EF);
        $display("test chan a done");

        @(posedge ref_clk);
        straps <= '{polarity: 1'b0, span: 1'b1};
        commit(dioa_pkg::OFF_CHA_LOW, 16'h0000, 1'b0, 0, 16'h01EF);
        chk_val("range held", 16'h0002, {14'h0000, pol, spn});
        commit(dioa_pkg::OFF_CHA_HIGH, 16'h0000, 1'b0, 1, 16'h0000);
        chk_val("range applied", 16'h0001, {14'h0000, pol, spn});
        commit(dioa_pkg::OFF_CHA_LOW, 16'hFFFF, 1'b1, 1, 16'hFFFF);
        @(posedge ref_clk);
        align <= 1'b0;
        commit(dioa_pkg::OFF_CHA_LOW, 16'hABCD, 1'b1, 1, 16'hBCD0);
        commit(dioa_pkg::OFF_CHA_HIGH, 16'h0007, 1'b0, 1, 16'h7CD0);
        @(posedge ref_clk);
        align <= 1'b1;
        u0 = upd_cnt;
        host_u.write_pair(16'h0078, 16'h0090);
        settle();
        chk_cnt("pair update", u0 + 1, upd_cnt);
        chk_val("pair code", 16'h9078, code);
        $display("test range and align done");

        pulse0(9, 0);
        pulse0(14, 14);
        $display("test trigger done");

        do_reset(1'b0);
        final_report();
    end
endmodule
